//--- hdl/sgps_pkg.sv
package sgps_pkg;
  // Clock and supervision tick
  localparam int CLK_NS   = 50;
  localparam int TICK_NS  = 1000000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
  localparam int TW       = 16;
  localparam int AW       = 6;

  // Register byte offsets
  localparam logic [AW-1:0] A_CTRL   = 6'h00;
  localparam logic [AW-1:0] A_CFG    = 6'h04;
  localparam logic [AW-1:0] A_TCLOSE = 6'h08;
  localparam logic [AW-1:0] A_TOPEN  = 6'h0c;
  localparam logic [AW-1:0] A_TSETL  = 6'h10;
  localparam logic [AW-1:0] A_STAT   = 6'h14;
  localparam logic [AW-1:0] A_IRQ    = 6'h18;
  localparam logic [AW-1:0] A_MASK   = 6'h1c;

  // Field positions
  localparam int CMD_CLOSE  = 0;
  localparam int CMD_OPEN   = 1;
  localparam int WIRE_CL    = 0;
  localparam int WIRE_OP    = 1;
  localparam int STB_POS    = 0;
  localparam int STB_CLOSED = 2;
  localparam int STB_OPEN   = 3;
  localparam int STB_MOVING = 4;
  localparam int STB_FAULT  = 5;
  localparam int STB_ONE    = 6;
  localparam int STB_SUCC   = 7;
  localparam int STB_DRV_CL = 8;
  localparam int STB_DRV_OP = 9;
  localparam int EV_SUCC    = 0;
  localparam int EV_FAULT   = 1;
  localparam int EV_POS     = 2;

  // Values after reset
  localparam logic [1:0]    RST_WIRED = 2'h3;
  localparam logic [TW-1:0] RST_TCL   = 16'h0064;
  localparam logic [TW-1:0] RST_TOP   = 16'h0064;
  localparam logic [TW-1:0] RST_TSETL = 16'h0000;

  // Position codes
  localparam logic [1:0] POS_MOVING = 2'h0;
  localparam logic [1:0] POS_OPEN   = 2'h1;
  localparam logic [1:0] POS_CLOSED = 2'h2;
  localparam logic [1:0] POS_FAULT  = 2'h3;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_CLOSING = 2'b01,
    ST_SETTLE  = 2'b11,
    ST_OPENING = 2'b10
  } sgps_state_e;
endpackage

//--- hdl/sgps_sync.sv
`timescale 1ns/1ns
module sgps_sync #(
  parameter int W = 2
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } sgps_sync_s;

  sgps_sync_s st;
  sgps_sync_s next_st;

  always_comb begin
    next_st    = st;
    next_st.s1 = async_in;
    next_st.s2 = st.s1;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_out = st.s2;
endmodule

//--- hdl/sgps_timer.sv
`timescale 1ns/1ns
module sgps_timer (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // Control
  input  wire logic                   start,
  input  wire logic                   stop,
  input  wire logic                   tick,
  input  wire logic [sgps_pkg::TW-1:0] load,
  // Expiry pulse
  output logic                        done
);
  typedef struct packed {
    logic                    run;
    logic                    done;
    logic [sgps_pkg::TW-1:0] cnt;
  } sgps_timer_s;

  sgps_timer_s st;
  sgps_timer_s next_st;

  always_comb begin
    next_st      = st;
    next_st.done = 1'b0;
    if (stop) begin
      next_st.run = 1'b0;
    end else if (start) begin
      next_st.run = 1'b1;
      next_st.cnt = load;
    end else if (st.run && (st.cnt == '0)) begin
      next_st.run  = 1'b0;
      next_st.done = 1'b1;
    end else if (st.run && tick) begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign done = st.done;
endmodule

//--- hdl/sgps_top.sv
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns
module sgps_top #(
  parameter int TICK_CYCLES = sgps_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   rst_n,
  // Avalon-MM slave
  input  wire logic [sgps_pkg::AW-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  output logic      [31:0]            avs_readdata,
  output logic                        avs_waitrequest,
  // Auxiliary contacts
  input  wire logic                   aux_closed,
  input  wire logic                   aux_open,
  // Command relay drives
  output logic                        close_drive,
  output logic                        open_drive,
  // Position indication
  output logic                        closed_flag,
  output logic                        open_flag,
  output logic                        moving_flag,
  output logic                        faulted_flag,
  output logic [1:0]                  pos_code,
  output logic                        one_contact_flag,
  output logic                        command_success_flag,
  // Interrupt
  output logic                        irq
);
  localparam int TW = sgps_pkg::TW;

  typedef struct packed {
    sgps_pkg::sgps_state_e fsm;
    logic                  sup;
    logic                  dir_cl;
    logic                  fault;
    logic                  forced;
    logic                  succ;
    logic                  drv_cl;
    logic                  drv_op;
    logic [1:0]            pos;
    logic [1:0]            wired;
    logic [TW-1:0]         t_cl;
    logic [TW-1:0]         t_op;
    logic [TW-1:0]         t_st;
    logic [2:0]            irq_st;
    logic [2:0]            irq_mask;
    logic                  served;
    logic [31:0]           rdata;
    logic [31:0]           tdiv;
    logic                  tick;
    logic [31:0]           drv_cyc;
  } sgps_top_s;

  sgps_top_s     st;
  sgps_top_s     next_st;
  logic [1:0]    aux_s;
  logic          cl;
  logic          op;
  logic          tr_start;
  logic          tr_stop;
  logic          tr_done;
  logic [TW-1:0] tr_load;
  logic          se_start;
  logic          se_done;
  logic          req;
  logic          acc;
  logic          wr_acc;
  logic          both;
  logic          one_w;
  logic          hit;
  logic          move_n;
  logic          clr_irq;
  logic          cmd_cl;
  logic          cmd_op;
  logic [2:0]    ev;
  logic [31:0]   rd;
  logic [31:0]   stat;
  logic [TW-1:0] tmax;

  sgps_sync #(
    .W(2)
  ) u_sync (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .async_in ({aux_open, aux_closed}),
    .sync_out (aux_s)
  );

  sgps_timer u_travel (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (tr_start),
    .stop    (tr_stop),
    .tick    (st.tick),
    .load    (tr_load),
    .done    (tr_done)
  );

  sgps_timer u_settle (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .start   (se_start),
    .stop    (1'b0),
    .tick    (st.tick),
    .load    (st.t_st),
    .done    (se_done)
  );

  assign cl = aux_s[0];
  assign op = aux_s[1];

  always_comb begin
    next_st  = st;
    tr_start = 1'b0;
    tr_stop  = 1'b0;
    tr_load  = st.t_op;
    se_start = 1'b0;
    hit      = 1'b0;
    ev       = '0;
    rd       = '0;
    stat     = '0;
    cmd_cl   = 1'b0;
    cmd_op   = 1'b0;
    clr_irq  = 1'b0;
    req      = avs_read | avs_write;
    acc      = req & st.served;
    wr_acc   = acc & avs_write;
    both     = &st.wired;
    one_w    = ^st.wired;
    // Supervision tick divider
    next_st.tick = 1'b0;
    if (st.tdiv >= 32'(TICK_CYCLES - 1)) begin
      next_st.tdiv = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.tdiv = st.tdiv + 32'h1;
    end
    stat[sgps_pkg::STB_POS +: 2]  = st.pos;
    stat[sgps_pkg::STB_CLOSED]    = st.pos == sgps_pkg::POS_CLOSED;
    stat[sgps_pkg::STB_OPEN]      = st.pos == sgps_pkg::POS_OPEN;
    stat[sgps_pkg::STB_MOVING]    = st.pos == sgps_pkg::POS_MOVING;
    stat[sgps_pkg::STB_FAULT]     = st.pos == sgps_pkg::POS_FAULT;
    stat[sgps_pkg::STB_ONE]       = one_w;
    stat[sgps_pkg::STB_SUCC]      = st.succ;
    stat[sgps_pkg::STB_DRV_CL]    = st.drv_cl;
    stat[sgps_pkg::STB_DRV_OP]    = st.drv_op;
    case (avs_address)
      sgps_pkg::A_CFG:    rd[1:0]    = st.wired;
      sgps_pkg::A_TCLOSE: rd[TW-1:0] = st.t_cl;
      sgps_pkg::A_TOPEN:  rd[TW-1:0] = st.t_op;
      sgps_pkg::A_TSETL:  rd[TW-1:0] = st.t_st;
      sgps_pkg::A_STAT:   rd         = stat;
      sgps_pkg::A_IRQ:    rd[2:0]    = st.irq_st;
      sgps_pkg::A_MASK:   rd[2:0]    = st.irq_mask;
      default:            rd         = '0;
    endcase
    // Answer one cycle after the request; read data and clear-on-read at that edge
    next_st.served = req & ~st.served;
    if (avs_read && !st.served) begin
      next_st.rdata = rd;
      clr_irq       = avs_address == sgps_pkg::A_IRQ;
    end
    if (wr_acc) begin
      case (avs_address)
        sgps_pkg::A_CTRL: begin
          cmd_cl = avs_writedata[sgps_pkg::CMD_CLOSE];
          cmd_op = avs_writedata[sgps_pkg::CMD_OPEN];
        end
        sgps_pkg::A_CFG:    next_st.wired    = avs_writedata[1:0];
        sgps_pkg::A_TCLOSE: next_st.t_cl     = avs_writedata[TW-1:0];
        sgps_pkg::A_TOPEN:  next_st.t_op     = avs_writedata[TW-1:0];
        sgps_pkg::A_TSETL:  next_st.t_st     = avs_writedata[TW-1:0];
        sgps_pkg::A_MASK:   next_st.irq_mask = avs_writedata[2:0];
        default: ;
      endcase
    end
    unique case (st.fsm)
      sgps_pkg::ST_IDLE: begin
        if (cmd_cl || cmd_op) begin
          // Open wins when both are written together
          next_st.dir_cl = ~cmd_op;
          next_st.sup    = cmd_op ? st.wired[sgps_pkg::WIRE_OP]
                                  : st.wired[sgps_pkg::WIRE_CL];
          next_st.fault  = 1'b0;
          next_st.forced = 1'b0;
          next_st.succ   = 1'b0;
          next_st.drv_cl = ~cmd_op;
          next_st.drv_op = cmd_op;
          tr_load        = cmd_op ? st.t_op : st.t_cl;
          tr_start       = 1'b1;
          next_st.fsm    = cmd_op ? sgps_pkg::ST_OPENING : sgps_pkg::ST_CLOSING;
        end
      end
      sgps_pkg::ST_CLOSING, sgps_pkg::ST_OPENING: begin
        hit = st.sup && (st.dir_cl ? cl && !(st.wired[sgps_pkg::WIRE_OP] && op)
                                   : op && !(st.wired[sgps_pkg::WIRE_CL] && cl));
        if (hit) begin
          tr_stop        = 1'b1;
          next_st.drv_cl = 1'b0;
          next_st.drv_op = 1'b0;
          next_st.succ   = 1'b1;
          next_st.fsm    = sgps_pkg::ST_IDLE;
          ev[sgps_pkg::EV_SUCC] = 1'b1;
        end else if (tr_done) begin
          next_st.drv_cl = 1'b0;
          next_st.drv_op = 1'b0;
          if (!st.sup) begin
            next_st.fsm = sgps_pkg::ST_IDLE;
          end else if (one_w && (st.t_st != '0)) begin
            se_start    = 1'b1;
            next_st.fsm = sgps_pkg::ST_SETTLE;
          end else begin
            next_st.fault = 1'b1;
            next_st.fsm   = sgps_pkg::ST_IDLE;
            ev[sgps_pkg::EV_FAULT] = 1'b1;
          end
        end
      end
      sgps_pkg::ST_SETTLE: begin
        if (se_done) begin
          next_st.forced = 1'b1;
          next_st.fsm    = sgps_pkg::ST_IDLE;
        end
      end
    endcase
    // Position from next state and synchronised contacts
    move_n = (next_st.fsm != sgps_pkg::ST_IDLE) && next_st.sup;
    if (next_st.wired == 2'h0) begin
      next_st.pos = sgps_pkg::POS_FAULT;
    end else if (move_n) begin
      next_st.pos = sgps_pkg::POS_MOVING;
    end else if (next_st.fault) begin
      next_st.pos = sgps_pkg::POS_FAULT;
    end else if (next_st.forced) begin
      next_st.pos = next_st.dir_cl ? sgps_pkg::POS_CLOSED : sgps_pkg::POS_OPEN;
    end else if (&next_st.wired) begin
      if (cl && !op) begin
        next_st.pos = sgps_pkg::POS_CLOSED;
      end else if (op && !cl) begin
        next_st.pos = sgps_pkg::POS_OPEN;
      end else begin
        next_st.pos = sgps_pkg::POS_FAULT;
      end
    end else if (next_st.wired[sgps_pkg::WIRE_CL]) begin
      next_st.pos = cl ? sgps_pkg::POS_CLOSED : sgps_pkg::POS_OPEN;
    end else begin
      next_st.pos = op ? sgps_pkg::POS_OPEN : sgps_pkg::POS_CLOSED;
    end
    ev[sgps_pkg::EV_POS] = next_st.pos != st.pos;
    // Event beats a clear-on-read in the same cycle
    next_st.irq_st  = (clr_irq ? 3'h0 : st.irq_st) | ev;
    next_st.drv_cyc = (st.drv_cl || st.drv_op) ? st.drv_cyc + 32'h1 : 32'h0;
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      st       <= '0;
      st.wired <= sgps_pkg::RST_WIRED;
      st.t_cl  <= sgps_pkg::RST_TCL;
      st.t_op  <= sgps_pkg::RST_TOP;
      st.t_st  <= sgps_pkg::RST_TSETL;
    end else begin
      st <= next_st;
    end
  end

  assign avs_waitrequest      = req & ~st.served;
  assign avs_readdata         = st.rdata;
  assign close_drive          = st.drv_cl;
  assign open_drive           = st.drv_op;
  assign pos_code             = st.pos;
  assign closed_flag          = st.pos == sgps_pkg::POS_CLOSED;
  assign open_flag            = st.pos == sgps_pkg::POS_OPEN;
  assign moving_flag          = st.pos == sgps_pkg::POS_MOVING;
  assign faulted_flag         = st.pos == sgps_pkg::POS_FAULT;
  assign one_contact_flag     = one_w;
  assign command_success_flag = st.succ;
  assign irq                  = |(st.irq_st & st.irq_mask);
  assign tmax                 = (st.t_cl > st.t_op) ? st.t_cl : st.t_op;

  a_close_moving: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    st.fsm == sgps_pkg::ST_CLOSING && st.sup |-> moving_flag && close_drive)
    else $error("close travel not shown as moving");

  a_close_hit: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    st.fsm == sgps_pkg::ST_CLOSING && st.sup && both && cl && !op && !wr_acc
    |=> closed_flag && command_success_flag && !close_drive)
    else $error("closed feedback did not end close travel");

  a_open_hit: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    st.fsm == sgps_pkg::ST_OPENING && st.sup && op && !(both && cl) && !wr_acc
    |=> open_flag && !open_drive && st.fsm == sgps_pkg::ST_IDLE)
    else $error("open feedback did not end open travel");

  a_expire_fault: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (st.fsm == sgps_pkg::ST_CLOSING || st.fsm == sgps_pkg::ST_OPENING) && st.sup
    && tr_done && !hit && (both || st.t_st == '0) && !wr_acc
    |=> faulted_flag && !moving_flag)
    else $error("expiry did not give faulted");

  a_drive_limit: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    st.drv_cyc <= (32'(tmax) + 32'h1) * 32'(TICK_CYCLES) + 32'h2)
    else $error("command drive outlasted its travel time");

  a_pair_code: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    both && st.fsm == sgps_pkg::ST_IDLE && !st.fault && !st.forced && !wr_acc
    |=> pos_code == (($past(cl) == $past(op)) ? sgps_pkg::POS_FAULT
                     : ($past(cl) ? sgps_pkg::POS_CLOSED : sgps_pkg::POS_OPEN)))
    else $error("two-contact position code wrong");

  a_one_nofault: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    one_contact_flag && $stable(st.wired) && st.fsm == sgps_pkg::ST_IDLE && !st.fault
    |-> !faulted_flag)
    else $error("single contact gave faulted without timeout");

  a_unsup_still: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    st.fsm != sgps_pkg::ST_IDLE && !st.sup |-> !moving_flag)
    else $error("unsupervised direction shown as moving");

  a_settle_moving: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    st.fsm == sgps_pkg::ST_SETTLE && se_done && !wr_acc
    |-> moving_flag ##1 (st.dir_cl ? closed_flag : open_flag))
    else $error("settle delay end not shown as position");

  a_none_wired: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    st.wired == 2'h0 && !wr_acc |=> pos_code == sgps_pkg::POS_FAULT)
    else $error("no contact wired but code not faulted");
endmodule

//--- tb/sgps_gear_model.sv
`timescale 1ns/1ns
module sgps_gear_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  // Relay drives and scenario knobs
  input  wire logic       close_drive,
  input  wire logic       open_drive,
  input  wire logic [7:0] delay,
  input  wire logic       stuck,
  input  wire logic       mid_hi,
  // Auxiliary contacts
  output logic            aux_closed,
  output logic            aux_open
);
  logic       is_closed;
  logic       in_travel;
  logic       target;
  logic [7:0] cnt;
  logic       prev_cl;
  logic       prev_op;

  // A drive edge starts travel; a stuck gear never arrives
  always @(posedge sys_clk) begin
    prev_cl <= close_drive;
    prev_op <= open_drive;
    if (!rst_n) begin
      is_closed <= 1'b0;
      in_travel <= 1'b0;
    end else if ((close_drive && !prev_cl) || (open_drive && !prev_op)) begin
      in_travel <= 1'b1;
      target    <= !open_drive;
      cnt       <= delay;
    end else if (in_travel && !stuck) begin
      if (cnt == 8'h00) begin
        in_travel <= 1'b0;
        is_closed <= target;
      end else begin
        cnt <= cnt - 8'h01;
      end
    end
  end

  // Mid travel both contacts show the same level
  assign aux_closed = in_travel ? mid_hi : is_closed;
  assign aux_open   = in_travel ? mid_hi : !is_closed;
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  localparam int TK = 4;
  logic                    sys_clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic [sgps_pkg::AW-1:0] avs_address = '0;
  logic                    avs_read = 1'b0;
  logic                    avs_write = 1'b0;
  logic [31:0]             avs_writedata = '0;
  logic [31:0]             avs_readdata;
  logic                    avs_waitrequest, aux_closed, aux_open, close_drive, open_drive;
  logic                    closed_flag, open_flag, moving_flag, faulted_flag;
  logic                    one_contact_flag, command_success_flag, irq;
  logic [1:0]              pos_code;
  logic [7:0]              delay = 8'h03;
  logic                    stuck = 1'b0;
  logic                    mid_hi = 1'b0;
  logic [63:0]             exp_q[$];
  logic [31:0]             rs = 32'hb05a;
  int                      bad_count = 0;
  int                      checks_done = 0;
  int                      len_cl, len_op, mov_cnt, tc, n;

  always #25 sys_clk = ~sys_clk;

  sgps_top #(.TICK_CYCLES(TK)) sgps_top_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .aux_closed(aux_closed), .aux_open(aux_open),
    .close_drive(close_drive), .open_drive(open_drive), .closed_flag(closed_flag),
    .open_flag(open_flag), .moving_flag(moving_flag), .faulted_flag(faulted_flag),
    .pos_code(pos_code), .one_contact_flag(one_contact_flag),
    .command_success_flag(command_success_flag), .irq(irq));

  sgps_gear_model sgps_gear_model_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .close_drive(close_drive), .open_drive(open_drive), .delay(delay), .stuck(stuck),
    .mid_hi(mid_hi), .aux_closed(aux_closed), .aux_open(aux_open));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Read results are compared against the oldest note as they appear
  always @(negedge sys_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      check("readdata", avs_readdata & exp_q[0][63:32], exp_q[0][31:0]);
      void'(exp_q.pop_front());
    end
    if (close_drive === 1'b1) len_cl++;
    if (open_drive === 1'b1) len_op++;
    if (moving_flag === 1'b1) mov_cnt++;
  end

  task automatic bus(input logic [sgps_pkg::AW-1:0] a, input logic wr, input logic [31:0] d);
    logic w;
    avs_address   <= a;
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= d;
    w = 1'b1;
    // Only the watchdog ends a request that is never answered
    while (w !== 1'b0) begin
      @(negedge sys_clk);
      w = avs_waitrequest;
      @(posedge sys_clk);
    end
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [sgps_pkg::AW-1:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [sgps_pkg::AW-1:0] a, input logic [31:0] e,
                    input logic [31:0] m);
    exp_q.push_back({m, e});
    bus(a, 1'b0, 32'h0);
  endtask

  // Issue a command, optionally a second one while busy, and wait for the drives to drop
  task automatic cmd(input logic [31:0] c, input logic [31:0] c2);
    len_cl = 0;
    len_op = 0;
    mov_cnt = 0;
    n = 0;
    wr(sgps_pkg::A_CTRL, c);
    if (c2 != 0) wr(sgps_pkg::A_CTRL, c2);
    do begin
      @(negedge sys_clk);
      n++;
    end while ((close_drive === 1'b1 || open_drive === 1'b1) && n < 3000);
    if (n >= 3000) bad_count++;
    @(posedge sys_clk);
  endtask

  task automatic pos_is(input logic [1:0] p);
    check("pos_code", pos_code, p);
    check("closed_flag", closed_flag, p == 2'h2);
    check("open_flag", open_flag, p == 2'h1);
    check("faulted_flag", faulted_flag, p == 2'h3);
  endtask

  initial begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(sgps_pkg::A_CFG, 32'h3, 32'h3);
    rd(sgps_pkg::A_TCLOSE, 32'h64, 32'hffff);
    rd(sgps_pkg::A_TOPEN, 32'h64, 32'hffff);
    rd(sgps_pkg::A_TSETL, 32'h0, 32'hffff);
    wr(6'h20, 32'hffffffff);
    rd(6'h20, 32'h0, 32'hffffffff);
    rd(sgps_pkg::A_STAT, 32'h9, 32'h3ff);
    pos_is(sgps_pkg::POS_OPEN);
    check("one_contact_flag", one_contact_flag, 1'b0);
    $display("test reset_values done");

    rs = xs(rs);
    tc = 4 + int'(rs[2:0]);
    delay <= 8'h06 + {6'h0, rs[4:3]};
    wr(sgps_pkg::A_TCLOSE, tc);
    wr(sgps_pkg::A_TOPEN, tc);
    wr(sgps_pkg::A_MASK, 32'h7);
    rd(sgps_pkg::A_IRQ, 32'h4, 32'h7);
    cmd(32'h1, 32'h2);
    pos_is(sgps_pkg::POS_CLOSED);
    check("success", command_success_flag, 1'b1);
    check("busy_open_ignored", len_op, 0);
    check("early_release", len_cl < int'(delay) + 8, 1'b1);
    check("moving_seen", mov_cnt > 0, 1'b1);
    check("irq_set", irq, 1'b1);
    rd(sgps_pkg::A_IRQ, 32'h5, 32'h7);
    check("irq_cleared", irq, 1'b0);
    $display("test close_prompt done");

    for (int i = 0; i < 2; i++) begin
      mid_hi <= i[0];
      stuck  <= 1'b1;
      cmd(i == 0 ? 32'h2 : 32'h1, 32'h0);
      pos_is(sgps_pkg::POS_FAULT);
      check("moving_dropped", moving_flag, 1'b0);
      check("moving_while_timing", mov_cnt >= (tc - 1) * TK, 1'b1);
      check("drive_len", (len_cl + len_op) <= (tc + 1) * TK, 1'b1);
      check("drive_len_min", (len_cl + len_op) >= (tc - 1) * TK, 1'b1);
      rd(sgps_pkg::A_IRQ, 32'h2, 32'h2);
    end
    stuck <= 1'b0;
    cmd(32'h1, 32'h0);
    pos_is(sgps_pkg::POS_CLOSED);
    cmd(32'h2, 32'h0);
    pos_is(sgps_pkg::POS_OPEN);
    check("success", command_success_flag, 1'b1);
    $display("test travel_faults done");

    wr(sgps_pkg::A_CFG, 32'h1);
    repeat (4) @(posedge sys_clk);
    check("one_contact_flag", one_contact_flag, 1'b1);
    pos_is(sgps_pkg::POS_OPEN);
    cmd(32'h1, 32'h0);
    pos_is(sgps_pkg::POS_CLOSED);
    check("success", command_success_flag, 1'b1);
    cmd(32'h2, 32'h0);
    check("unsupervised_moving", mov_cnt, 0);
    check("unsupervised_len", len_op >= (tc - 1) * TK, 1'b1);
    pos_is(sgps_pkg::POS_OPEN);
    wr(sgps_pkg::A_TSETL, 32'h3);
    stuck <= 1'b1;
    mid_hi <= 1'b0;
    cmd(32'h1, 32'h0);
    mov_cnt = 0;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (moving_flag === 1'b1 && n < 500);
    if (n >= 500) bad_count++;
    @(posedge sys_clk);
    check("settle_min", mov_cnt >= 2 * TK, 1'b1);
    check("settle_max", mov_cnt <= 4 * TK + 2, 1'b1);
    pos_is(sgps_pkg::POS_CLOSED);
    $display("test closed_only done");

    stuck <= 1'b0;
    wr(sgps_pkg::A_TSETL, 32'h0);
    wr(sgps_pkg::A_CFG, 32'h2);
    cmd(32'h2, 32'h0);
    check("one_contact_flag", one_contact_flag, 1'b1);
    pos_is(sgps_pkg::POS_OPEN);
    check("success", command_success_flag, 1'b1);
    cmd(32'h1, 32'h0);
    check("unsupervised_moving", mov_cnt, 0);
    pos_is(sgps_pkg::POS_CLOSED);
    $display("test open_only done");

    wr(sgps_pkg::A_MASK, 32'h0);
    rd(sgps_pkg::A_IRQ, 32'h5, 32'h7);
    wr(sgps_pkg::A_CFG, 32'h0);
    repeat (4) @(posedge sys_clk);
    pos_is(sgps_pkg::POS_FAULT);
    check("irq_masked", irq, 1'b0);
    rd(sgps_pkg::A_IRQ, 32'h4, 32'h4);
    $display("test unassigned done");
    complete_run();
  end

  initial begin
    #(50 * 20000);
    bad_count++;
    complete_run();
  end
endmodule
